// File: logic/dbm_pkg.sv
// Notes on behaviour
// [RL1] two banks: count one, copy the other
// [RL2] swap from front-panel pulse or bus command
// [RL3] 32 channels, 32-bit counters, 24-bit mode
// [RL4] internal 10 MHz pulser can drive swaps
// [RL5] prescaler swaps on every Nth source pulse
// [RL6] copy: 120 ns per word plus 260 ns; the overhead rounds up to 7 clocks, 280 ns
// [RL7] copy-disable mask skips channels, shortens copy
// [RL8] copy-in-progress output spans each copy exactly
// [RL9] each 32-bit value is two 18-bit entries
// [RL10] FIFO reads rejoin two entries into 32 bits
// [RL11] once full, no data until FIFO clear
// [RL12] half-full and almost-full flags for polling
// [RL13] count needs channel and global enable
// [RL14] test bit picks test pulses over inputs
// [RL15] master spaces swaps beyond the copy time
// [RL16] FIFO holds 64K entries
// [RL17] 24-bit mode carries two user bits
// [RL18] any write to 0x024 forces a next event; it swaps only with next logic on and no copy running
// [RL19] copy start sets sticky status bit 28
// [RL20] idle bank cleared after its copy
package dbm_pkg;
  localparam int ADDR_W = 11;
  localparam logic [10:0] OFF_STATUS = 11'h000;
  localparam logic [10:0] OFF_CTRL = 11'h008;
  localparam logic [10:0] OFF_COPY_DIS = 11'h00c;
  localparam logic [10:0] OFF_CHAN_EN = 11'h014;
  localparam logic [10:0] OFF_CLEAR = 11'h020;
  localparam logic [10:0] OFF_NEXT = 11'h024;
  localparam logic [10:0] OFF_NEXT_ON = 11'h028;
  localparam logic [10:0] OFF_NEXT_OFF = 11'h02c;
  localparam logic [10:0] OFF_RESET = 11'h060;
  localparam logic [10:0] OFF_TEST_PULSE = 11'h068;
  localparam logic [10:0] OFF_PRESC = 11'h080;
  localparam logic [2:0] FIFO_WIN = 3'h1;

  localparam int CTL_GLOBAL_EN = 0;
  localparam int CTL_TEST = 1;
  localparam int CTL_INT_PULSER = 2;
  localparam int CTL_EXT_NEXT = 3;
  localparam int CTL_PRESC_EN = 4;
  localparam int CTL_MODE24 = 5;
  localparam int CTL_W = 6;

  localparam int ST_CIP_START = 28;
  localparam int ST_NEXT_EXT = 16;
  localparam int ST_NEXT_EN = 15;
  localparam int ST_FULL = 12;
  localparam int ST_ALMOST_FULL = 11;
  localparam int ST_HALF_FULL = 10;
  localparam int ST_ALMOST_EMPTY = 9;
  localparam int ST_EMPTY = 8;
  localparam int ST_PRESC_EN = 7;
  localparam int ST_INT_PULSER = 6;
  localparam int ST_TEST = 5;
  localparam int ST_MODE24 = 1;
  localparam int ST_CIP = 0;

  localparam int FIFO_AW = 16;
  localparam int FIFO_DW = 18;
  localparam logic [16:0] FIFO_DEPTH = 17'h10000;
  localparam logic [16:0] FIFO_HALF = 17'h08000;
  localparam logic [16:0] FIFO_ALMOST_FULL = 17'h0ff80;
  localparam logic [16:0] FIFO_ALMOST_EMPTY = 17'h00040;

  localparam int CLK_PERIOD_NS = 40;
  localparam int WORD_NS = 120;
  localparam int OVH_NS = 260;
  localparam int WORD_CYC = (WORD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OVH_CYC = (OVH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] WORD_LAST = 3'(WORD_CYC - 1);
  localparam logic [2:0] OVH_LAST = 3'(OVH_CYC - 1);
  localparam int CLK_MHZ = 25;
  localparam int PULSER_MHZ = 10;
  localparam logic [5:0] PULSE_STEP = 6'(PULSER_MHZ);
  localparam logic [5:0] PULSE_MOD = 6'(CLK_MHZ);

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_OVH = 3'b010,
    ST_COPY = 3'b100
  } dbm_copy_st_t;

  typedef struct packed {
    logic en;
    logic [FIFO_AW-1:0] addr;
    logic [FIFO_DW-1:0] data;
  } dbm_fifo_wr_t;

  typedef struct packed {
    dbm_copy_st_t st;
    logic [2:0] tcnt;
    logic act;
    logic [31:0] pend;
    logic [1:0][31:0][31:0] bank;
    logic [CTL_W-1:0] ctrl;
    logic [31:0] copy_dis;
    logic [31:0] chan_en;
    logic [27:0] presc;
    logic [27:0] presc_cnt;
    logic [5:0] pacc;
    logic next_en;
    logic cip_start;
    logic fifo_stop;
    logic [FIFO_AW-1:0] wptr;
    logic [FIFO_AW-1:0] rptr;
    logic [16:0] cnt;
    logic [31:0] in_prev;
    logic ne_prev;
    logic test_pulse;
    logic [31:0] rdata;
    logic copy_in_progress;
    logic hf;
    logic af;
  } dbm_core_t;
endpackage

// File: logic/dbm_fifo_mem.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_fifo_mem
  import dbm_pkg::*;
(
  input wire logic clk_i,                        // core clock
  input wire dbm_fifo_wr_t wr_i,                 // write request
  input wire logic [FIFO_AW-1:0] raddr_a_i,      // read address, low half
  input wire logic [FIFO_AW-1:0] raddr_b_i,      // read address, high half
  output logic [FIFO_DW-1:0] rdata_a_o,          // registered low half
  output logic [FIFO_DW-1:0] rdata_b_o           // registered high half
);
  logic [FIFO_DW-1:0] mem [0:(1<<FIFO_AW)-1];

  // write-through keeps the head valid when a pair lands on an empty fifo
  always_ff @(posedge clk_i) begin
    if (wr_i.en) begin
      mem[wr_i.addr] <= wr_i.data;
    end
    if (wr_i.en && wr_i.addr == raddr_a_i) begin
      rdata_a_o <= wr_i.data;
    end else begin
      rdata_a_o <= mem[raddr_a_i];
    end
    if (wr_i.en && wr_i.addr == raddr_b_i) begin
      rdata_b_o <= wr_i.data;
    end else begin
      rdata_b_o <= mem[raddr_b_i];
    end
  end
endmodule
`default_nettype wire

// File: logic/dbm_core.sv
// Implementation choices: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dbm_core
  import dbm_pkg::*;
(
  input wire logic MCLK_I,                     // 25 MHz core clock
  input wire logic RESET_N_I,                  // sync reset, active low
  input wire logic [ADDR_W-1:0] ADDR_I,        // register byte address
  input wire logic [31:0] WDATA_I,             // write data
  input wire logic WR_I,                       // write strobe
  input wire logic RD_I,                       // read strobe
  input wire logic [31:0] CNT_IN_I,            // front-panel count inputs
  input wire logic NEXT_EVENT_I,               // front-panel next event
  input wire logic [1:0] USER_BITS_I,          // user bits, 24-bit mode
  output logic [31:0] RDATA_O,                 // read data, cycle after
  output logic COPY_IN_PROGRESS_O,             // bank copy running
  output logic FIFO_HALF_FULL_O,               // fifo half full
  output logic FIFO_ALMOST_FULL_O              // fifo almost full
);
  dbm_core_t r;
  dbm_core_t next_r;
  dbm_fifo_wr_t fw;
  logic [FIFO_AW-1:0] raddr_a;
  logic [FIFO_AW-1:0] raddr_b;
  logic [FIFO_DW-1:0] head_lo;
  logic [FIFO_DW-1:0] head_hi;

  function automatic logic [4:0] low_bit(input logic [31:0] p);
    logic [4:0] k;
    k = 5'h00;
    for (int i = 31; i >= 0; i--) begin
      if (p[i]) begin
        k = 5'(i);
      end
    end
    return k;
  endfunction

  dbm_fifo_mem u_mem (
    .clk_i(MCLK_I),
    .wr_i(fw),
    .raddr_a_i(raddr_a),
    .raddr_b_i(raddr_b),
    .rdata_a_o(head_lo),
    .rdata_b_o(head_hi)
  );

  always_comb begin
    logic [4:0] ch;
    logic idle;
    logic tsel;
    logic tick;
    logic src;
    logic fire;
    logic swap;
    logic push;
    logic pop;
    logic finish;
    logic [5:0] psum;
    logic [31:0] cval;
    logic [31:0] word;
    logic [31:0] status;
    next_r = r;
    fw = '0;
    ch = low_bit(r.pend);
    idle = ~r.act;
    tsel = 1'b0;
    tick = 1'b0;
    fire = 1'b0;
    src = 1'b0;
    swap = 1'b0;
    pop = 1'b0;
    psum = '0;
    status = '0;
    push = 1'b0;
    finish = 1'b0;
    cval = r.bank[idle][ch];
    word = cval;
    next_r.in_prev = CNT_IN_I;
    next_r.ne_prev = NEXT_EVENT_I;
    next_r.test_pulse = WR_I && ADDR_I == OFF_TEST_PULSE;

    if (WR_I) begin
      case (ADDR_I)
        OFF_STATUS: begin
          if (WDATA_I[ST_CIP_START]) begin
            next_r.cip_start = 1'b0;
          end
        end
        OFF_CTRL: next_r.ctrl = WDATA_I[CTL_W-1:0];
        OFF_COPY_DIS: next_r.copy_dis = WDATA_I;
        OFF_CHAN_EN: next_r.chan_en = WDATA_I;
        OFF_NEXT_ON: next_r.next_en = 1'b1;
        OFF_NEXT_OFF: next_r.next_en = 1'b0;
        OFF_PRESC: begin
          next_r.presc = WDATA_I[27:0];
          next_r.presc_cnt = '0;
        end
        default: ;
      endcase
    end

    // counting always lands in the active bank, never the one being copied
    for (int i = 0; i < 32; i++) begin
      tsel = r.ctrl[CTL_TEST] ? r.test_pulse                  // [RL14]
                              : (CNT_IN_I[i] && !r.in_prev[i]);
      if (tsel && r.ctrl[CTL_GLOBAL_EN] && r.chan_en[i]) begin  // [RL13]
        next_r.bank[r.act][i] = r.bank[r.act][i] + 32'h1;       // [RL1] [RL3]
      end
    end

    // 10 MHz from 25 MHz: two ticks every five cycles, so jitter of one
    // clock is traded for no second oscillator
    psum = r.pacc + PULSE_STEP;
    if (psum >= PULSE_MOD) begin
      next_r.pacc = psum - PULSE_MOD;
      tick = 1'b1;                                               // [RL4]
    end else begin
      next_r.pacc = psum;
    end
    src = r.ctrl[CTL_INT_PULSER] ? tick                          // [RL4]
        : (r.ctrl[CTL_EXT_NEXT] && NEXT_EVENT_I && !r.ne_prev);  // [RL2]
    if (src) begin
      if (r.ctrl[CTL_PRESC_EN]) begin
        if (r.presc_cnt + 28'h1 >= r.presc) begin                // [RL5]
          fire = 1'b1;
          next_r.presc_cnt = '0;
        end else begin
          next_r.presc_cnt = r.presc_cnt + 28'h1;
        end
      end else begin
        fire = 1'b1;
      end
    end
    if (WR_I && ADDR_I == OFF_NEXT) begin
      fire = 1'b1;                                               // [RL18] [RL2]
    end
    swap = fire && r.next_en;

    if (r.ctrl[CTL_MODE24]) begin
      word = {6'h00, USER_BITS_I, cval[23:0]};                   // [RL17]
    end

    unique case (r.st)
      ST_IDLE: begin
        // a swap during a copy is dropped; spacing is the master's job
        if (swap) begin                                          // [RL15]
          next_r.act = ~r.act;                                   // [RL1]
          next_r.st = ST_OVH;
          next_r.tcnt = '0;
          next_r.pend = ~r.copy_dis;                             // [RL7]
          next_r.copy_in_progress = 1'b1;                                     // [RL8]
        end
      end
      ST_OVH: begin
        if (r.tcnt == OVH_LAST) begin                            // [RL6]
          next_r.tcnt = '0;
          if (r.pend == '0) begin
            finish = 1'b1;
          end else begin
            next_r.st = ST_COPY;
          end
        end else begin
          next_r.tcnt = r.tcnt + 3'h1;
        end
      end
      ST_COPY: begin
        if (r.tcnt == 3'h0) begin
          push = 1'b1;
          fw.data = {2'h0, word[15:0]};                          // [RL9]
        end else if (r.tcnt == 3'h1) begin
          push = 1'b1;
          fw.data = {2'h1, word[31:16]};                         // [RL9]
        end
        if (r.tcnt == WORD_LAST) begin                           // [RL6]
          next_r.tcnt = '0;
          next_r.pend[ch] = 1'b0;                                // [RL7]
          if (next_r.pend == '0) begin
            finish = 1'b1;
          end
        end else begin
          next_r.tcnt = r.tcnt + 3'h1;
        end
      end
    endcase

    if (finish) begin
      next_r.bank[idle] = '0;                                    // [RL20]
      next_r.st = ST_IDLE;
      next_r.copy_in_progress = 1'b0;                                         // [RL8]
    end

    // set wins over a software clear in the same cycle
    if (r.st == ST_IDLE && swap) begin
      next_r.cip_start = 1'b1;                                   // [RL19]
    end

    // full latches a stop: the rest of the copy is thrown away
    if (push && !r.fifo_stop) begin                              // [RL11]
      fw.en = 1'b1;
      fw.addr = r.wptr;
      next_r.wptr = r.wptr + 16'h1;
    end
    pop = RD_I && ADDR_I[10:8] == FIFO_WIN && ADDR_I[1:0] == 2'h0
        && r.cnt >= 17'h00002;
    if (pop) begin
      next_r.rptr = r.rptr + 16'h2;
    end
    next_r.cnt = r.cnt + {16'h0000, fw.en} - (pop ? 17'h00002 : 17'h00000);
    if (next_r.cnt == FIFO_DEPTH) begin
      next_r.fifo_stop = 1'b1;                                   // [RL11] [RL16]
    end

    status = '0;
    status[ST_CIP_START] = r.cip_start;                          // [RL19]
    status[ST_NEXT_EXT] = r.ctrl[CTL_EXT_NEXT];
    status[ST_NEXT_EN] = r.next_en;
    status[ST_FULL] = r.cnt == FIFO_DEPTH;
    status[ST_ALMOST_FULL] = r.af;
    status[ST_HALF_FULL] = r.hf;
    status[ST_ALMOST_EMPTY] = r.cnt <= FIFO_ALMOST_EMPTY;
    status[ST_EMPTY] = r.cnt == '0;
    status[ST_PRESC_EN] = r.ctrl[CTL_PRESC_EN];
    status[ST_INT_PULSER] = r.ctrl[CTL_INT_PULSER];
    status[ST_TEST] = r.ctrl[CTL_TEST];
    status[ST_MODE24] = r.ctrl[CTL_MODE24];
    status[ST_CIP] = r.copy_in_progress;

    next_r.rdata = '0;
    if (RD_I) begin
      if (ADDR_I[10:8] == FIFO_WIN) begin
        if (pop) begin
          next_r.rdata = {head_hi[15:0], head_lo[15:0]};         // [RL10]
        end
      end else begin
        case (ADDR_I)
          OFF_STATUS: next_r.rdata = status;
          OFF_CTRL: next_r.rdata = {26'h0, r.ctrl};
          OFF_COPY_DIS: next_r.rdata = r.copy_dis;
          OFF_CHAN_EN: next_r.rdata = r.chan_en;
          OFF_PRESC: next_r.rdata = {4'h0, r.presc};
          default: next_r.rdata = '0;
        endcase
      end
    end

    // fifo clear key: data, pointers, stop, banks and copy sequence
    if (WR_I && ADDR_I == OFF_CLEAR) begin                       // [RL11]
      next_r.wptr = '0;
      next_r.rptr = '0;
      next_r.cnt = '0;
      next_r.fifo_stop = 1'b0;
      next_r.bank = '0;
      next_r.st = ST_IDLE;
      next_r.tcnt = '0;
      next_r.pend = '0;
      next_r.copy_in_progress = 1'b0;
      next_r.presc_cnt = '0;
      fw.en = 1'b0;
    end

    next_r.hf = next_r.cnt >= FIFO_HALF;                         // [RL12]
    next_r.af = next_r.cnt >= FIFO_ALMOST_FULL;                  // [RL12]
    raddr_a = next_r.rptr;
    raddr_b = next_r.rptr + 16'h1;
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I || (WR_I && ADDR_I == OFF_RESET)) begin
      r <= '0;
      r.st <= ST_IDLE;
    end else begin
      r <= next_r;
    end
  end

  assign RDATA_O = r.rdata;
  assign COPY_IN_PROGRESS_O = r.copy_in_progress;
  assign FIFO_HALF_FULL_O = r.hf;
  assign FIFO_ALMOST_FULL_O = r.af;
endmodule
`default_nettype wire

// File: dv/dbm_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_core_asserts
  import dbm_pkg::*;
(
  input wire logic MCLK_I, // core clock
  input wire logic RESET_N_I, // sync reset
  input wire logic [ADDR_W-1:0] ADDR_I, // address
  input wire logic WR_I, // write strobe
  input wire logic RD_I, // read strobe
  input wire logic [31:0] RDATA_O, // read data
  input wire logic COPY_IN_PROGRESS_O, // copy running
  input wire logic FIFO_HALF_FULL_O, // half full
  input wire logic FIFO_ALMOST_FULL_O // almost full
);
  logic copy_in_progress;
  logic nen;
  assign copy_in_progress = COPY_IN_PROGRESS_O;
  // shadow of the next-logic enable, seen only through key writes
  always_ff @(posedge MCLK_I) begin
    if (!RESET_N_I) begin
      nen <= 1'b0;
    end else if (WR_I && ADDR_I == OFF_NEXT_ON) begin
      nen <= 1'b1;
    end else if (WR_I && (ADDR_I == OFF_NEXT_OFF || ADDR_I == OFF_RESET)) begin
      nen <= 1'b0;
    end
  end
  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESET_N_I);
  a_rd_quiet: assert property (!$past(RD_I) |-> RDATA_O == 32'h0)
    else $error("read data outside its slot");
  a_status_cip: assert property (
    RD_I && ADDR_I == OFF_STATUS |=> RDATA_O[ST_CIP] == $past(copy_in_progress))
    else $error("status copy bit differs from output");
  a_copy_min: assert property ($rose(copy_in_progress) |-> copy_in_progress[*7])
    else $error("copy shorter than overhead");
  a_copy_max: assert property ($rose(copy_in_progress) |-> ##[7:103] !copy_in_progress)
    else $error("copy longer than 32 words");
  a_cmd_swap: assert property (
    WR_I && ADDR_I == OFF_NEXT && nen && !copy_in_progress && !$past(copy_in_progress) |=> copy_in_progress)
    else $error("command did not start a copy");
  a_swap_off: assert property (!nen && !copy_in_progress |=> !copy_in_progress)
    else $error("copy started with next logic off");
  a_clear_abort: assert property (
    WR_I && ADDR_I == OFF_CLEAR |=> !copy_in_progress && !FIFO_HALF_FULL_O)
    else $error("fifo clear left copy or flag");
  a_key_reset: assert property (
    WR_I && ADDR_I == OFF_RESET |=> !copy_in_progress && !FIFO_ALMOST_FULL_O)
    else $error("reset key left copy or flag");
  a_flag_order: assert property (FIFO_ALMOST_FULL_O |-> FIFO_HALF_FULL_O)
    else $error("almost full without half full");
  c_copy: cover property ($rose(copy_in_progress));
  c_fifo_rd: cover property (RD_I && ADDR_I == 11'h100);
  c_cmd: cover property (WR_I && ADDR_I == OFF_NEXT && nen);
endmodule
bind dbm_core dbm_core_asserts u_chk (.MCLK_I, .RESET_N_I, .ADDR_I, .WR_I,
  .RD_I, .RDATA_O, .COPY_IN_PROGRESS_O, .FIFO_HALF_FULL_O,
  .FIFO_ALMOST_FULL_O);
`default_nettype wire

// File: dv/dbm_bus_master.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_bus_master
  import dbm_pkg::*;
(
  input wire logic clk_i, // core clock
  input wire logic [31:0] rdata_i, // read data
  input wire logic cip_i, // copy running
  output logic [ADDR_W-1:0] addr_o = '0, // address
  output logic [31:0] wdata_o = '0, // write data
  output logic wr_o = 1'b0, // write strobe
  output logic rd_o = 1'b0 // read strobe
);
  // each access starts an edge later so a strobe never toggles twice
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    d = rdata_i;
  endtask
  task automatic wait_idle();
    int n = 0;
    while (cip_i !== 1'b0 && n < 200) begin
      @(posedge clk_i);
      n++;
    end
  endtask
  // holds off a software next event until the previous copy is done
  task automatic next_ev();
    wait_idle();
    wr(OFF_NEXT, 32'h5a5a_5a5a);
    @(posedge clk_i);
    wait_idle();
    // one more edge lets length counters settle before callers look
    @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: dv/dbm_core_bench.sv
`timescale 1ns/1ps
`default_nettype none
module dbm_core_bench;
  import dbm_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [31:0] cnt_in = '0;
  logic nxt = 1'b0;
  logic [1:0] ubits = '0;
  logic [ADDR_W-1:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic wr;
  logic rd;
  logic copy_in_progress;
  logic hf;
  logic af;
  int error_cnt = 0;
  int checks_done = 0;
  int cip_run = 0;
  int cip_len = 0;
  int rises = 0;
  always #20 mclk = ~mclk;
  dbm_core u_dut (.MCLK_I(mclk), .RESET_N_I(rst_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .CNT_IN_I(cnt_in),
    .NEXT_EVENT_I(nxt), .USER_BITS_I(ubits), .RDATA_O(rdata),
    .COPY_IN_PROGRESS_O(copy_in_progress), .FIFO_HALF_FULL_O(hf),
    .FIFO_ALMOST_FULL_O(af));
  dbm_bus_master u_bus (.clk_i(mclk), .rdata_i(rdata), .cip_i(copy_in_progress),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // copy length and swap count measured on the output pin itself
  always @(posedge mclk) begin
    cip_run <= copy_in_progress ? cip_run + 1 : 0;
    if (copy_in_progress && cip_run == 0) rises <= rises + 1;
    if (!copy_in_progress && cip_run != 0) cip_len <= cip_run;
  end
  task automatic chk(input string what, input logic [31:0] exp,
      input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic pulse(input logic [31:0] m, input int n, input logic e);
    repeat (n) begin
      @(posedge mclk);
      cnt_in <= m;
      nxt <= e;
      @(posedge mclk);
      cnt_in <= '0;
      nxt <= 1'b0;
    end
  endtask
  // channels 0-1 count, 0-2 copied: channel 2 proves the count enable
  task automatic setup(input logic [31:0] ctrl, input logic [31:0] presc);
    u_bus.wr(OFF_RESET, 32'h0);
    u_bus.wr(OFF_CLEAR, 32'h0);
    u_bus.wr(OFF_CHAN_EN, 32'h0000_0003);
    u_bus.wr(OFF_COPY_DIS, 32'hffff_fff8);
    u_bus.wr(OFF_PRESC, presc);
    u_bus.wr(OFF_NEXT_ON, 32'h0);
    u_bus.wr(OFF_CTRL, ctrl);
  endtask
  task automatic rd_fifo(input string what, input logic [31:0] exp);
    logic [31:0] d;
    u_bus.rd(11'h100, d);
    chk(what, exp, d);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    u_bus.rd(OFF_STATUS, d);
    chk("status", 32'h0000_0300, d);
    u_bus.wr(OFF_CTRL, 32'hffff_ffff);
    u_bus.rd(OFF_CTRL, d);
    chk("ctrl", 32'h0000_003f, d);
    u_bus.rd(11'h004, d);
    chk("unmapped", 32'h0, d);
    u_bus.rd(OFF_NEXT, d);
    chk("key read", 32'h0, d);
    $display("t_regs finished");
  endtask
  task automatic t_count();
    logic [31:0] exp[10] = '{32'h3, 32'h3, 32'h0, 32'h1, 32'h0, 32'h0,
      32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] d;
    setup(32'h1, 32'h0);
    pulse(32'h0000_0007, 3, 1'b0);
    u_bus.next_ev();
    chk("copy cycles", 32'(OVH_CYC + 3 * WORD_CYC), 32'(cip_len));
    pulse(32'h0000_0001, 1, 1'b0);
    u_bus.next_ev();
    u_bus.next_ev();
    foreach (exp[i]) rd_fifo("fifo word", exp[i]);
    u_bus.rd(OFF_STATUS, d);
    chk("status", 32'h1000_8300, d);
    chk("half full", 32'h0, {31'h0, hf});
    chk("almost full", 32'h0, {31'h0, af});
    $display("t_count finished");
  endtask
  task automatic t_test();
    setup(32'h2, 32'h0);
    u_bus.wr(OFF_TEST_PULSE, 32'h0);
    u_bus.wr(OFF_CTRL, 32'h3);
    u_bus.wr(OFF_TEST_PULSE, 32'h0);
    u_bus.wr(OFF_TEST_PULSE, 32'h0);
    pulse(32'h0000_0007, 2, 1'b0);
    u_bus.next_ev();
    rd_fifo("test ch0", 32'h2);
    rd_fifo("test ch1", 32'h2);
    rd_fifo("test ch2", 32'h0);
    $display("t_test finished");
  endtask
  task automatic t_ext();
    int r;
    setup(32'h19, 32'h3);
    r = rises;
    pulse(32'h0, 2, 1'b1);
    repeat (4) @(posedge mclk);
    chk("early swaps", 32'h0, 32'(rises - r));
    pulse(32'h0, 1, 1'b1);
    repeat (4) @(posedge mclk);
    chk("ext swaps", 32'h1, 32'(rises - r));
    u_bus.wait_idle();
    $display("t_ext finished");
  endtask
  task automatic t_pulser();
    int r;
    setup(32'h15, 32'h0000_000a);
    r = rises;
    repeat (500) @(posedge mclk);
    u_bus.wr(OFF_CTRL, 32'h0);
    @(posedge mclk);
    u_bus.wait_idle();
    r = rises - r;
    chk("pulser swaps", 32'h1, 32'(r >= 19 && r <= 21));
    $display("t_pulser finished");
  endtask
  task automatic t_mode24();
    setup(32'h21, 32'h0);
    ubits <= 2'b10;
    pulse(32'h0000_0001, 1, 1'b0);
    u_bus.next_ev();
    rd_fifo("mode24 ch0", 32'h0200_0001);
    $display("t_mode24 finished");
  endtask
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    t_regs();
    t_count();
    t_test();
    t_ext();
    t_pulser();
    t_mode24();
    stop_test();
  end
  // the whole run needs some 800 cycles; twenty-five times that means a hang
  initial begin
    repeat (20000) @(posedge mclk);
    error_cnt++;
    stop_test();
  end
endmodule
`default_nettype wire
